// ---- hw/attr_remap.sv ----
// Memory attribute remap: banked remap registers and three lookup lanes.
// Assumes a privileged register access port driven by the core pipeline and
// lookup requests from fetch, data and table walk in the core clock domain.
`timescale 1ns/1ps
module attr_remap
  import attr_remap_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Control
  input  wire logic [31:0] system_control_reg_i,
  input  wire logic        icache_en_i,
  input  wire logic        secure_cfg_write_lock_i,
  // Register access port
  input  wire logic        acc_valid_i,
  input  wire logic        acc_write_i,
  input  wire logic        acc_sel_i,
  input  wire logic        acc_secure_i,
  input  wire logic        acc_priv_i,
  input  wire logic [31:0] acc_wdata_i,
  output logic             acc_done_o,
  output logic             acc_undef_o,
  output logic [31:0]      acc_rdata_o,
  // Lookup sources
  input  wire lookup_req_t fetch_req_i,
  input  wire lookup_req_t data_req_i,
  input  wire lookup_req_t walk_req_i,
  output lookup_rsp_t      fetch_rsp_o,
  output lookup_rsp_t      data_rsp_o,
  output lookup_rsp_t      walk_rsp_o
);

  // Index 1 holds the Secure copy, index 0 the Non-secure copy
  logic [31:0] prim_q [2];
  logic [31:0] norm_q [2];
  logic        remap_en;
  logic        allowed;
  logic        bank;

  assign remap_en = system_control_reg_i[REMAP_ENABLE_BIT];
  assign allowed  = acc_priv_i && !(acc_write_i && secure_cfg_write_lock_i);
  assign bank     = acc_secure_i;

  // ----------------------------------------------------------------
  // Remap registers
  // ----------------------------------------------------------------
  // Primary copies, reserved fields never stored
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prim_q <= '{default: PRIMARY_RESET};
    end else if (acc_valid_i && acc_write_i && allowed && acc_sel_i == SEL_PRIMARY) begin
      prim_q[bank] <= acc_wdata_i & PRIMARY_WRITE_MASK;
    end
  end

  // Normal copies, index 6 fields never stored
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      norm_q <= '{default: NORMAL_RESET};
    end else if (acc_valid_i && acc_write_i && allowed && acc_sel_i == SEL_NORMAL) begin
      norm_q[bank] <= acc_wdata_i & NORMAL_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Access answer
  // ----------------------------------------------------------------
  // Completion and undefined-instruction flags
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_done_o  <= 1'b0;
      acc_undef_o <= 1'b0;
    end else begin
      acc_done_o  <= acc_valid_i;
      acc_undef_o <= acc_valid_i && !allowed;
    end
  end

  // Read data, zero when refused or on writes
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_rdata_o <= 32'h0000_0000;
    end else if (acc_valid_i && !acc_write_i && allowed) begin
      acc_rdata_o <= (acc_sel_i == SEL_NORMAL) ? norm_q[bank] : prim_q[bank];
    end else begin
      acc_rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Lookup lanes
  // ----------------------------------------------------------------
  // Instruction fetch lane
  attr_remap_lane #(
    .IS_FETCH (1'b1)
  ) u_fetch_lane (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .remap_en_i  (remap_en),
    .icache_en_i (icache_en_i),
    .prim_s_i    (prim_q[1]),
    .prim_ns_i   (prim_q[0]),
    .norm_s_i    (norm_q[1]),
    .norm_ns_i   (norm_q[0]),
    .req_i       (fetch_req_i),
    .rsp_o       (fetch_rsp_o)
  );

  // Data access lane
  attr_remap_lane #(
    .IS_FETCH (1'b0)
  ) u_data_lane (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .remap_en_i  (remap_en),
    .icache_en_i (icache_en_i),
    .prim_s_i    (prim_q[1]),
    .prim_ns_i   (prim_q[0]),
    .norm_s_i    (norm_q[1]),
    .norm_ns_i   (norm_q[0]),
    .req_i       (data_req_i),
    .rsp_o       (data_rsp_o)
  );

  // Table walk lane
  attr_remap_lane #(
    .IS_FETCH (1'b0)
  ) u_walk_lane (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .remap_en_i  (remap_en),
    .icache_en_i (icache_en_i),
    .prim_s_i    (prim_q[1]),
    .prim_ns_i   (prim_q[0]),
    .norm_s_i    (norm_q[1]),
    .norm_ns_i   (norm_q[0]),
    .req_i       (walk_req_i),
    .rsp_o       (walk_rsp_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Helper view of the walk and data requests
  logic [2:0]  w_idx;
  logic [31:0] w_prim;
  logic [31:0] w_norm;
  logic [31:0] d_prim;
  logic        rst_seen_q;

  assign w_idx  = {walk_req_i.tex0, walk_req_i.cacheable, walk_req_i.bufferable};
  assign w_prim = walk_req_i.secure ? prim_q[1] : prim_q[0];
  assign w_norm = walk_req_i.secure ? norm_q[1] : norm_q[0];
  assign d_prim = data_req_i.secure ? prim_q[1] : prim_q[0];

  // Marks the first cycle after reset release
  always_ff @(posedge clk_i) begin
    rst_seen_q <= !rst_b_i;
  end

  sequence user_access_s;
    acc_valid_i && !acc_priv_i;
  endsequence

  sequence locked_write_s;
    acc_valid_i && acc_write_i && acc_priv_i && secure_cfg_write_lock_i;
  endsequence

  sequence walk_remap_s;
    walk_req_i.valid && walk_req_i.mmu_on && remap_en;
  endsequence

  prim_reset_a: assert property (rst_seen_q |-> prim_q[0] == PRIMARY_RESET
                                 && prim_q[1] == PRIMARY_RESET)
    else $error("primary remap copy not at reset value");

  norm_reset_a: assert property (rst_seen_q |-> norm_q[0] == NORMAL_RESET
                                 && norm_q[1] == NORMAL_RESET)
    else $error("normal remap copy not at reset value");

  raz_fields_a: assert property ((prim_q[bank] & ~PRIMARY_WRITE_MASK) == 32'h0000_0000
                                 && (norm_q[bank] & ~NORMAL_WRITE_MASK) == 32'h0000_0000)
    else $error("reserved remap bits hold a value");

  user_undef_a: assert property (user_access_s |=> acc_undef_o && acc_done_o
                                 && acc_rdata_o == 32'h0000_0000)
    else $error("user access not refused");

  lock_block_a: assert property (locked_write_s |=> $stable(prim_q[0])
                                 && $stable(prim_q[1]) && $stable(norm_q[0])
                                 && $stable(norm_q[1]) && acc_undef_o)
    else $error("locked write changed a remap copy");

  bypass_attr_a: assert property (data_req_i.valid && data_req_i.mmu_on && !remap_en
                                  |=> data_rsp_o.mem_type == $past(data_req_i.mem_type)
                                  && data_rsp_o.inner == $past(data_req_i.inner))
    else $error("attributes changed while remap is off");

  type_lookup_a: assert property (walk_remap_s |=> walk_rsp_o.valid
                                  && walk_rsp_o.mem_type == $past(w_prim[{w_idx, 1'b0} +: 2]))
    else $error("walk type not taken from the indexed field");

  normal_share_a: assert property (walk_remap_s ##0 w_prim[{w_idx, 1'b0} +: 2] == TYPE_NORMAL
                                   |=> walk_rsp_o.shareable == $past(walk_req_i.shareable
                                   ? w_prim[NORMAL_SHARE_WHEN_SET]
                                   : w_prim[NORMAL_SHARE_WHEN_CLEAR]))
    else $error("normal shareable remap wrong");

  device_share_a: assert property (data_req_i.valid && data_req_i.mmu_on && remap_en
                                   && d_prim[{data_req_i.tex0, data_req_i.cacheable,
                                              data_req_i.bufferable, 1'b0} +: 2] == TYPE_DEVICE
                                   |=> data_rsp_o.shareable == $past(data_req_i.shareable
                                   ? d_prim[DEVICE_SHARE_WHEN_SET]
                                   : d_prim[DEVICE_SHARE_WHEN_CLEAR]))
    else $error("device shareable remap wrong");

  normal_cache_a: assert property (walk_remap_s
                                   ##0 w_prim[{w_idx, 1'b0} +: 2] == TYPE_NORMAL
                                   |=> walk_rsp_o.outer == $past(w_norm[{1'b1, w_idx, 1'b0} +: 2])
                                   && walk_rsp_o.inner == $past(w_norm[{w_idx, 1'b0} +: 2]))
    else $error("normal cacheability remap wrong");

  fetch_default_a: assert property (fetch_req_i.valid && !fetch_req_i.mmu_on && !remap_en
                                    |=> fetch_rsp_o.mem_type == ($past(icache_en_i)
                                    ? TYPE_NORMAL : TYPE_STRONG))
    else $error("translation-off fetch default wrong");

  data_default_a: assert property (data_req_i.valid && !data_req_i.mmu_on && !remap_en
                                   |=> data_rsp_o.mem_type == TYPE_STRONG
                                   && data_rsp_o.shareable)
    else $error("translation-off data default wrong");

endmodule // attr_remap

// ---- shared/attr_remap_pkg.sv ----
// Constants, field layouts and carrier types for the memory attribute remap.
// Assumes one core clock domain and privileged register access via the
// register access port of the remap block.
package attr_remap_pkg;

  // ----------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------
  localparam int unsigned REMAP_ENABLE_BIT = 28;

  // ----------------------------------------------------------------
  // Register selection on the access port
  // ----------------------------------------------------------------
  localparam logic SEL_PRIMARY = 1'b0;
  localparam logic SEL_NORMAL  = 1'b1;

  // ----------------------------------------------------------------
  // Primary type remap layout
  // ----------------------------------------------------------------
  localparam int unsigned NORMAL_SHARE_WHEN_SET   = 19;
  localparam int unsigned NORMAL_SHARE_WHEN_CLEAR = 18;
  localparam int unsigned DEVICE_SHARE_WHEN_SET   = 17;
  localparam int unsigned DEVICE_SHARE_WHEN_CLEAR = 16;
  localparam int unsigned OUTER_FIELD_BASE        = 16;
  localparam logic [31:0] PRIMARY_WRITE_MASK      = 32'h000F_CFFF;
  localparam logic [31:0] PRIMARY_RESET           = 32'h0009_8AA4;

  // ----------------------------------------------------------------
  // Normal cacheability remap layout
  // ----------------------------------------------------------------
  localparam logic [31:0] NORMAL_WRITE_MASK = 32'hCFFF_CFFF;
  localparam logic [31:0] NORMAL_RESET      = 32'h44E0_48E0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_STRONG = 2'h0;
  localparam logic [1:0] TYPE_DEVICE = 2'h1;
  localparam logic [1:0] TYPE_NORMAL = 2'h2;
  localparam logic [1:0] CACHE_NONE  = 2'h0;
  localparam logic [1:0] CACHE_WBWA  = 2'h1;
  localparam logic [1:0] CACHE_WT    = 2'h2;
  localparam logic [1:0] CACHE_WBNA  = 2'h3;

  // Index used for the translation-off defaults
  localparam logic [2:0] IDX_STRONG_DEFAULT = 3'h0;
  localparam logic [2:0] IDX_FETCH_DEFAULT  = 3'h7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       secure;
    logic       mmu_on;
    logic       tex0;
    logic       cacheable;
    logic       bufferable;
    logic       shareable;
    logic [1:0] mem_type;
    logic [1:0] inner;
    logic [1:0] outer;
  } lookup_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] mem_type;
    logic       shareable;
    logic [1:0] inner;
    logic [1:0] outer;
  } lookup_rsp_t;

endpackage

// ---- hw/attr_remap_lane.sv ----
// One lookup lane: turns one source's translation attributes into final ones.
// Assumes the remap register copies are stable flops in the parent.
`timescale 1ns/1ps
module attr_remap_lane
  import attr_remap_pkg::*;
#(
  parameter bit IS_FETCH = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Control
  input  wire logic        remap_en_i,
  input  wire logic        icache_en_i,
  // Register copies
  input  wire logic [31:0] prim_s_i,
  input  wire logic [31:0] prim_ns_i,
  input  wire logic [31:0] norm_s_i,
  input  wire logic [31:0] norm_ns_i,
  // Lookup
  input  wire lookup_req_t req_i,
  output lookup_rsp_t      rsp_o
);

  logic [2:0]  idx;
  logic [31:0] prim;
  logic [31:0] norm;
  lookup_rsp_t base;
  lookup_rsp_t rsp_d;

  // ----------------------------------------------------------------
  // Attribute formation
  // ----------------------------------------------------------------
  // Defaults when translation is off, else table attributes
  always_comb begin
    prim = req_i.secure ? prim_s_i : prim_ns_i;
    norm = req_i.secure ? norm_s_i : norm_ns_i;
    base.valid = req_i.valid;
    if (!req_i.mmu_on) begin
      if (IS_FETCH && icache_en_i) begin
        idx            = IDX_FETCH_DEFAULT;
        base.mem_type  = TYPE_NORMAL;
        base.shareable = 1'b0;
        base.inner     = CACHE_WBWA;
        base.outer     = CACHE_WBWA;
      end else begin
        idx            = IDX_STRONG_DEFAULT;
        base.mem_type  = TYPE_STRONG;
        base.shareable = 1'b1;
        base.inner     = CACHE_NONE;
        base.outer     = CACHE_NONE;
      end
    end else begin
      idx            = {req_i.tex0, req_i.cacheable, req_i.bufferable};
      base.mem_type  = req_i.mem_type;
      base.shareable = req_i.shareable;
      base.inner     = req_i.inner;
      base.outer     = req_i.outer;
    end
  end

  // ----------------------------------------------------------------
  // Remap stage
  // ----------------------------------------------------------------
  // Overrides attributes while remapping is on
  always_comb begin
    rsp_d = base;
    if (remap_en_i) begin
      rsp_d.mem_type = prim[{idx, 1'b0} +: 2];
      case (rsp_d.mem_type)
        TYPE_NORMAL: rsp_d.shareable = base.shareable ? prim[NORMAL_SHARE_WHEN_SET]
                                                      : prim[NORMAL_SHARE_WHEN_CLEAR];
        TYPE_DEVICE: rsp_d.shareable = base.shareable ? prim[DEVICE_SHARE_WHEN_SET]
                                                      : prim[DEVICE_SHARE_WHEN_CLEAR];
        default:     rsp_d.shareable = 1'b1;
      endcase
      if (rsp_d.mem_type == TYPE_NORMAL) begin
        rsp_d.inner = norm[{idx, 1'b0} +: 2];
        rsp_d.outer = norm[{1'b1, idx, 1'b0} +: 2];
      end else begin
        rsp_d.inner = CACHE_NONE;
        rsp_d.outer = CACHE_NONE;
      end
    end
  end

  // Result register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= rsp_d;
    end
  end

endmodule // attr_remap_lane

// ---- verification/lookup_source.sv ----
// Partner model: the walk and TLB lookup sources feeding the three remap lanes.
// Assumes the bench calls issue() from one process, one request at a time.
`timescale 1ns/1ps
module lookup_source
  import attr_remap_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Requests to the lanes
  output lookup_req_t fetch_req_o,
  output lookup_req_t data_req_o,
  output lookup_req_t walk_req_o
);
  // Idle sources at time zero
  initial begin
    fetch_req_o = '0;
    data_req_o  = '0;
    walk_req_o  = '0;
  end

  // One request cycle on every lane, then idle with scrambled fields
  task automatic issue(input lookup_req_t r);
    lookup_req_t idle;
    @(posedge clk_i);
    fetch_req_o <= r;
    data_req_o  <= r;
    walk_req_o  <= r;
    @(posedge clk_i);
    idle        = ~r;
    idle.valid  = 1'b0;
    fetch_req_o <= idle;
    data_req_o  <= idle;
    walk_req_o  <= idle;
  endtask
endmodule // lookup_source

// ---- verification/memory_attribute_remap_tb.sv ----
// Self-checking bench for the attribute remap block.
// Assumes the lookup_source partner drives all three lookup lanes.
`timescale 1ns/1ps
module memory_attribute_remap_tb;
  import attr_remap_pkg::*;
  logic        clk_i;
  logic        rst_b_i;
  logic [31:0] sctl;
  logic        icache_en;
  logic        lock;
  logic        acc_valid;
  logic        acc_write;
  logic        acc_sel;
  logic        acc_secure;
  logic        acc_priv;
  logic [31:0] acc_wdata;
  logic [31:0] acc_rdata;
  logic        acc_done;
  logic        acc_undef;
  lookup_req_t fetch_req;
  lookup_req_t data_req;
  lookup_req_t walk_req;
  lookup_rsp_t fetch_rsp;
  lookup_rsp_t data_rsp;
  lookup_rsp_t walk_rsp;
  logic [31:0] prim_m [2];
  logic [31:0] norm_m [2];
  int          n_errors;
  int          num_checks;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #4 clk_i = ~clk_i;

  attr_remap dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .system_control_reg_i(sctl),
    .icache_en_i(icache_en), .secure_cfg_write_lock_i(lock),
    .acc_valid_i(acc_valid), .acc_write_i(acc_write), .acc_sel_i(acc_sel),
    .acc_secure_i(acc_secure), .acc_priv_i(acc_priv), .acc_wdata_i(acc_wdata),
    .acc_done_o(acc_done), .acc_undef_o(acc_undef), .acc_rdata_o(acc_rdata),
    .fetch_req_i(fetch_req), .data_req_i(data_req), .walk_req_i(walk_req),
    .fetch_rsp_o(fetch_rsp), .data_rsp_o(data_rsp), .walk_rsp_o(walk_rsp)
  );

  lookup_source src (
    .clk_i(clk_i), .fetch_req_o(fetch_req), .data_req_o(data_req), .walk_req_o(walk_req)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access; done is looked at in its single cycle
  task automatic acc(input logic wr, input logic sel, input logic sec, input logic priv,
                     input logic [31:0] wd, output logic u, output logic [31:0] rd);
    @(posedge clk_i);
    acc_valid  <= 1'b1;
    acc_write  <= wr;
    acc_sel    <= sel;
    acc_secure <= sec;
    acc_priv   <= priv;
    acc_wdata  <= wd;
    @(posedge clk_i);
    acc_valid  <= 1'b0;
    #1;
    chk("acc_done", 32'h1, {31'h0, acc_done});
    u  = acc_undef;
    rd = acc_rdata;
  endtask

  // Expected lane answer worked out from the remap tables
  function automatic lookup_rsp_t ref_rsp(input lookup_req_t r, input bit fetch,
                                          input bit en, input bit ic);
    lookup_rsp_t o;
    int          n;
    logic [31:0] p;
    logic [31:0] m;
    p = prim_m[r.secure];
    m = norm_m[r.secure];
    n = {r.tex0, r.cacheable, r.bufferable};
    o = '{r.valid, r.mem_type, r.shareable, r.inner, r.outer};
    if (!r.mmu_on && fetch && ic) begin
      o = '{r.valid, 2'h2, 1'b0, 2'h1, 2'h1};
      n = 7;
    end else if (!r.mmu_on) begin
      o = '{r.valid, 2'h0, 1'b1, 2'h0, 2'h0};
      n = 0;
    end
    if (en) begin
      o.mem_type = p[2*n +: 2];
      o.inner    = 2'h0;
      o.outer    = 2'h0;
      case (o.mem_type)
        2'h2: begin
          o.shareable = o.shareable ? p[19] : p[18];
          o.inner     = m[2*n +: 2];
          o.outer     = m[16+2*n +: 2];
        end
        2'h1: o.shareable = o.shareable ? p[17] : p[16];
        default: o.shareable = 1'b1;
      endcase
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    logic        u;
    logic [31:0] rd;
    for (int s = 0; s < 2; s++) begin
      prim_m[s] = 32'h0009_8AA4;
      norm_m[s] = 32'h44E0_48E0;
      acc(1'b0, SEL_PRIMARY, s[0], 1'b1, 32'h0, u, rd);
      chk("prim_reset", prim_m[s], rd);
      acc(1'b0, SEL_NORMAL, s[0], 1'b1, 32'h0, u, rd);
      chk("norm_reset", norm_m[s], rd);
      chk("reset_undef", 32'h0, {31'h0, u});
    end
  endtask

  // All-ones then a pattern into the Secure copies; Non-secure must stay
  task automatic write_read();
    logic        u;
    logic [31:0] rd;
    acc(1'b1, SEL_PRIMARY, 1'b1, 1'b1, 32'hFFFF_FFFF, u, rd);
    acc(1'b0, SEL_PRIMARY, 1'b1, 1'b1, 32'h0, u, rd);
    chk("prim_ones", 32'h000F_CFFF, rd);
    acc(1'b1, SEL_NORMAL, 1'b1, 1'b1, 32'hFFFF_FFFF, u, rd);
    acc(1'b0, SEL_NORMAL, 1'b1, 1'b1, 32'h0, u, rd);
    chk("norm_ones", 32'hCFFF_CFFF, rd);
    acc(1'b1, SEL_PRIMARY, 1'b1, 1'b1, 32'hFFF6_4E1B, u, rd);
    acc(1'b1, SEL_NORMAL, 1'b1, 1'b1, 32'h9C6B_36E4, u, rd);
    prim_m[1] = 32'h0006_4E1B;
    norm_m[1] = 32'h8C6B_06E4;
    for (int s = 0; s < 2; s++) begin
      acc(1'b0, SEL_PRIMARY, s[0], 1'b1, 32'h0, u, rd);
      chk("prim_copy", prim_m[s], rd);
      acc(1'b0, SEL_NORMAL, s[0], 1'b1, 32'h0, u, rd);
      chk("norm_copy", norm_m[s], rd);
    end
  endtask

  task automatic refused();
    logic        u;
    logic [31:0] rd;
    @(posedge clk_i);
    lock <= 1'b1;
    acc(1'b1, SEL_PRIMARY, 1'b1, 1'b1, 32'h0, u, rd);
    chk("lock_undef", 32'h1, {31'h0, u});
    acc(1'b0, SEL_PRIMARY, 1'b1, 1'b1, 32'h0, u, rd);
    chk("lock_keep", prim_m[1], rd);
    @(posedge clk_i);
    lock <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      acc(1'b0, SEL_NORMAL, s[0], 1'b0, 32'h0, u, rd);
      chk("user_rd_undef", 32'h1, {31'h0, u});
      chk("user_rdata", 32'h0, rd);
      acc(1'b1, SEL_NORMAL, s[0], 1'b0, 32'h0, u, rd);
      chk("user_wr_undef", 32'h1, {31'h0, u});
      acc(1'b0, SEL_NORMAL, s[0], 1'b1, 32'h0, u, rd);
      chk("user_wr_keep", norm_m[s], rd);
    end
  endtask

  // Registers left static from here on, before any lookup relies on them
  task automatic lookups();
    lookup_req_t r;
    bit          en;
    bit          ic;
    for (int k = 0; k < 128; k++) begin
      r        = '0;
      r.valid  = 1'b1;
      r.secure = k[0];
      r.mmu_on = k[1];
      {r.tex0, r.cacheable, r.bufferable} = k[4:2];
      r.shareable = k[5];
      r.mem_type  = k[3:2];
      r.inner     = k[2:1];
      r.outer     = k[6:5];
      en = k[6];
      ic = k[0] ^ k[5];
      @(posedge clk_i);
      sctl      <= {3'h5, en, 28'h5A5_A5A5};
      icache_en <= ic;
      src.issue(r);
      #1;
      chk("fetch_rsp", 32'(ref_rsp(r, 1'b1, en, ic)), 32'(fetch_rsp));
      chk("data_rsp", 32'(ref_rsp(r, 1'b0, en, ic)), 32'(data_rsp));
      chk("walk_rsp", 32'(ref_rsp(r, 1'b0, en, ic)), 32'(walk_rsp));
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i      = 1'b0;
    rst_b_i    = 1'b0;
    sctl       = 32'h0;
    icache_en  = 1'b0;
    lock       = 1'b0;
    acc_valid  = 1'b0;
    acc_write  = 1'b0;
    acc_sel    = 1'b0;
    acc_secure = 1'b0;
    acc_priv   = 1'b0;
    acc_wdata  = 32'h0;
    n_errors   = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    reset_values();
    write_read();
    refused();
    lookups();
    give_verdict();
  end

  // About 430 cycles expected; cut a hang well beyond that
  initial begin
    #(8 * 5000);
    n_errors++;
    give_verdict();
  end
endmodule // memory_attribute_remap_tb
